// *** tx_regs.sv ***
// Transmit control register bank: stores the transmit path control words and drives
// the converter codes, general outputs, synthesizer word, power request and blanking.
// Assumes a single 25 MHz clock, synchronous active-high reset, and a register master
// on the same clock using one-cycle read and write strobes.
//
// Behaviour
// R1: A gain change blanks the baseband input for the interval picked by the blanking field.
// R2: Blanking code 0 means none, codes 1, 2, 3 give about 230, 540 and 850 ns.
// R3: Software keeps the common-mode adjust bit at zero.
// R4: Software sets the saturation threshold field to 0x1F.
// R5: Override enable hands the second converter and all four outputs to the override fields.
// R6: Each override output bit drives its own general output high, lowest bit to output one.
// R7: The converter two override field sets that converter only while override is enabled.
// R8: The low five bits of the override register set the first converter code.
// R9: The sixteen-bit frequency word programs the transmit synthesizer.
// R10: Software loads the channel frequency itself into the frequency word in high bands.
// R11: The twelve-bit power field is the requested power in 1/32 dBm steps from -80 dBm.
// R12: Software keeps requested power within -80 dBm to +10 dBm.
// R13: Software rewrites the power field periodically or every 5 degree temperature step.
// R14: With power bit 0 set, output power follows the requested power field.
// R15: Writing one to bit 4 of the reload register starts a nonvolatile memory reload.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module tx_regs (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Register port
   input  wire logic [4:0]  addr,
   input  wire logic [15:0] write_data,
   input  wire logic        write_strobe,
   input  wire logic        read_strobe,
   output logic      [15:0] read_data,
   // Gain change event from the transmit gain logic
   input  wire logic        gain_change,
   // Automatic second converter code used when override is off
   input  wire logic [5:0]  converter_two_auto,
   // Automatic general output levels used when override is off
   input  wire logic [3:0]  general_outputs_auto,
   // Reload engine handshake
   input  wire logic        reload_done,
   // Outputs to the transmit path
   output logic             baseband_blank,
   output logic             common_mode_adjust,
   output logic      [5:0]  saturation_threshold,
   output logic      [4:0]  first_control_converter,
   output logic      [5:0]  second_control_converter,
   output logic             general_output_one,
   output logic             general_output_two,
   output logic             general_output_three,
   output logic             general_output_four,
   output logic      [15:0] tx_synth_word,
   output logic      [11:0] tx_power_code,
   output logic             tx_power_manual,
   output logic             reload_start,
   output logic             reload_busy
);

   typedef struct packed {
      logic [15:0] tx_input_options;
      logic [15:0] output_override_control;
      logic [15:0] tx_frequency_word;
      logic [15:0] tx_power_request;
      logic [7:0]  blank_count;
      logic        blank;
      logic [7:0]  reload_count;
      logic        reload_pulse;
      logic        busy;
      logic [15:0] rdata;
      logic [5:0]  conv_two;
      logic [3:0]  gpo;
   } state_t;

   state_t current;
   state_t next_state;

   logic [1:0] blank_sel;
   logic [7:0] blank_len;
   logic       override_en;

   assign blank_sel   = current.tx_input_options[tx_regs_pkg::BLANK_SEL_LSB +: 2];
   assign override_en = current.output_override_control[tx_regs_pkg::OVERRIDE_EN_BIT];

   always_comb begin
      unique case (blank_sel) // R2
         2'h0: blank_len = 8'h00;
         2'h1: blank_len = tx_regs_pkg::BLANK_ONE_CYCLES;
         2'h2: blank_len = tx_regs_pkg::BLANK_TWO_CYCLES;
         2'h3: blank_len = tx_regs_pkg::BLANK_THREE_CYCLES;
      endcase
   end

   always_comb begin
      next_state = current;
      next_state.reload_pulse = 1'b0;
      next_state.rdata = 16'h0000;

      if (write_strobe) begin
         unique case (addr)
            tx_regs_pkg::ADDR_TX_INPUT_OPTIONS:  next_state.tx_input_options = write_data;
            tx_regs_pkg::ADDR_OUTPUT_OVERRIDE:   next_state.output_override_control = write_data;
            tx_regs_pkg::ADDR_TX_FREQUENCY_WORD: next_state.tx_frequency_word = write_data; // R9
            tx_regs_pkg::ADDR_TX_POWER_REQUEST:  next_state.tx_power_request = write_data;  // R11
            tx_regs_pkg::ADDR_MEMORY_RELOAD: begin
               // A trigger while a reload runs is ignored rather than restarting it
               if (write_data[tx_regs_pkg::RELOAD_BIT] && !current.busy) begin // R15
                  next_state.reload_pulse = 1'b1;
                  next_state.busy = 1'b1;
                  next_state.reload_count = tx_regs_pkg::RELOAD_CYCLES;
               end
            end
            default: ;
         endcase
      end

      // Busy ends on the engine's done or when the timeout count runs out
      if (current.busy && !current.reload_pulse) begin
         if (reload_done || current.reload_count == 8'h00) begin
            next_state.busy = 1'b0;
         end else begin
            next_state.reload_count = current.reload_count - 8'h01;
         end
      end

      // Blanking: a fresh gain change restarts the interval
      if (gain_change && blank_len != 8'h00) begin // R1
         next_state.blank = 1'b1;
         next_state.blank_count = blank_len - 8'h01;
      end else if (current.blank) begin
         if (current.blank_count == 8'h00) begin
            next_state.blank = 1'b0;
         end else begin
            next_state.blank_count = current.blank_count - 8'h01;
         end
      end

      if (override_en) begin // R5
         next_state.conv_two =
            current.output_override_control[tx_regs_pkg::CONV_TWO_LSB +: 6]; // R7
         next_state.gpo = current.output_override_control[tx_regs_pkg::OUT_BITS_LSB +: 4]; // R6
      end else begin
         next_state.conv_two = converter_two_auto;
         next_state.gpo = general_outputs_auto;
      end

      // Write-only registers read as zero; the status word shows busy and blanking
      if (read_strobe) begin
         unique case (addr)
            tx_regs_pkg::ADDR_TX_INPUT_OPTIONS: next_state.rdata = current.tx_input_options;
            tx_regs_pkg::ADDR_OUTPUT_OVERRIDE:  next_state.rdata = current.output_override_control;
            tx_regs_pkg::ADDR_STATUS:
               next_state.rdata = {14'h0000, current.blank, current.busy};
            default: next_state.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         current <= '0;
         current.tx_input_options <= tx_regs_pkg::RESET_TX_INPUT_OPTIONS;
         current.output_override_control <= tx_regs_pkg::RESET_OUTPUT_OVERRIDE;
         current.tx_frequency_word <= tx_regs_pkg::RESET_TX_FREQUENCY;
         current.tx_power_request <= tx_regs_pkg::RESET_TX_POWER;
      end else begin
         current <= next_state;
      end
   end

   assign read_data                = current.rdata;
   assign baseband_blank           = current.blank;
   assign common_mode_adjust       = current.tx_input_options[tx_regs_pkg::CM_ADJUST_BIT];
   assign saturation_threshold     = current.tx_input_options[tx_regs_pkg::SAT_THRES_LSB +: 6];
   assign first_control_converter  =
      current.output_override_control[tx_regs_pkg::CONV_ONE_LSB +: 5]; // R8
   assign second_control_converter = current.conv_two;
   assign general_output_one       = current.gpo[0];
   assign general_output_two       = current.gpo[1];
   assign general_output_three     = current.gpo[2];
   assign general_output_four      = current.gpo[3];
   assign tx_synth_word            = current.tx_frequency_word;
   assign tx_power_code            = current.tx_power_request[tx_regs_pkg::POWER_CODE_LSB +: 12];
   assign tx_power_manual          = current.tx_power_request[tx_regs_pkg::POWER_EN_BIT]; // R14
   assign reload_start             = current.reload_pulse;
   assign reload_busy              = current.busy;

endmodule : tx_regs

// *** tx_regs_pkg.sv ***
// Package for the transmit control register bank: offsets, field layouts, timing.
// Assumes a 25 MHz system clock and a plain strobe register port.
package tx_regs_pkg;
   // Register offsets (word index on the plain port)
   localparam logic [4:0] ADDR_TX_INPUT_OPTIONS  = 5'h15;
   localparam logic [4:0] ADDR_OUTPUT_OVERRIDE   = 5'h16;
   localparam logic [4:0] ADDR_TX_FREQUENCY_WORD = 5'h1A;
   localparam logic [4:0] ADDR_TX_POWER_REQUEST  = 5'h1C;
   localparam logic [4:0] ADDR_MEMORY_RELOAD     = 5'h1F;
   localparam logic [4:0] ADDR_STATUS            = 5'h00;

   // Field positions
   localparam int BLANK_SEL_LSB   = 7;
   localparam int CM_ADJUST_BIT   = 6;
   localparam int SAT_THRES_LSB   = 0;
   localparam int OVERRIDE_EN_BIT = 15;
   localparam int OUT_BITS_LSB    = 11;
   localparam int CONV_TWO_LSB    = 5;
   localparam int CONV_ONE_LSB    = 0;
   localparam int POWER_CODE_LSB  = 4;
   localparam int POWER_EN_BIT    = 0;
   localparam int RELOAD_BIT      = 4;

   // Reset values
   localparam logic [15:0] RESET_TX_INPUT_OPTIONS = 16'h001F;
   localparam logic [15:0] RESET_OUTPUT_OVERRIDE  = 16'h0000;
   localparam logic [15:0] RESET_TX_FREQUENCY     = 16'h0000;
   localparam logic [15:0] RESET_TX_POWER         = 16'h0000;

   // Blanking intervals and their cycle counts, rounded down
   localparam int CLOCK_HZ        = 25_000_000;
   localparam int BLANK_ONE_NS    = 230;
   localparam int BLANK_TWO_NS    = 540;
   localparam int BLANK_THREE_NS  = 850;
   localparam logic [7:0] BLANK_ONE_CYCLES   = 8'((BLANK_ONE_NS * (CLOCK_HZ / 1_000_000)) / 1000);
   localparam logic [7:0] BLANK_TWO_CYCLES   = 8'((BLANK_TWO_NS * (CLOCK_HZ / 1_000_000)) / 1000);
   localparam logic [7:0] BLANK_THREE_CYCLES =
      8'((BLANK_THREE_NS * (CLOCK_HZ / 1_000_000)) / 1000);

   // Nonvolatile reload sequence length in cycles
   localparam logic [7:0] RELOAD_CYCLES = 8'h20;
endpackage : tx_regs_pkg

// *** tx_regs_checker.sv ***
// Assertions for the transmit control register bank.
// Sees only the bank's ports; bound to it from the testbench top file.
`timescale 1ns/1ns
module tx_regs_checker (
   // Clock, reset, register port, gain change and automatic second converter code
   input wire logic        clock, rst, write_strobe, gain_change,
   input wire logic [4:0]  addr,
   input wire logic [15:0] write_data,
   input wire logic [5:0]  converter_two_auto,
   // Watched outputs
   input wire logic        baseband_blank, reload_start, reload_busy, tx_power_manual,
   input wire logic        general_output_one, general_output_two, general_output_three,
   input wire logic        general_output_four,
   input wire logic [4:0]  first_control_converter,
   input wire logic [5:0]  second_control_converter,
   input wire logic [15:0] tx_synth_word,
   input wire logic [11:0] tx_power_code
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [4:0] blank_len;
   logic       wr_ovr;
   assign wr_ovr = write_strobe && addr == tx_regs_pkg::ADDR_OUTPUT_OVERRIDE;
   // A new gain change restarts the count, so the length is measured from it
   always_ff @(posedge clock)
      if (rst || gain_change) blank_len <= 5'h00;
      else if (baseband_blank) blank_len <= blank_len + 5'h01;
   chk_blank_cause: assert property ($rose(baseband_blank) |-> $past(gain_change))
      else $error("blanking began without a gain change");
   chk_blank_length: assert property ($fell(baseband_blank) |-> blank_len inside {5, 13, 21})
      else $error("blanking interval has a wrong length");
   chk_conv_one: assert property (wr_ovr |=> first_control_converter == $past(write_data[4:0]))
      else $error("first converter code does not follow its field");
   chk_conv_two_ovr: assert property (wr_ovr && write_data[15] |-> ##2
      second_control_converter == $past(write_data[10:5], 2))
      else $error("second converter ignores the override field");
   chk_conv_two_auto: assert property (wr_ovr && !write_data[15] |-> ##2
      second_control_converter == $past(converter_two_auto))
      else $error("second converter overridden while override is off");
   chk_output_map: assert property (wr_ovr && write_data[15] |-> ##2 {general_output_four,
      general_output_three, general_output_two, general_output_one} == $past(write_data[14:11], 2))
      else $error("general outputs do not follow the override bits");
   chk_synth_word: assert property (write_strobe && addr == 5'h1A |=>
      tx_synth_word == $past(write_data))
      else $error("synthesizer word does not follow its register");
   chk_power_word: assert property (write_strobe && addr == 5'h1C |=>
      {tx_power_code, tx_power_manual} == {$past(write_data[15:4]), $past(write_data[0])})
      else $error("power request outputs do not follow their register");
   chk_reload_start: assert property (write_strobe && addr == 5'h1F && write_data[4]
      && !reload_busy |=> reload_start && reload_busy ##1 !reload_start)
      else $error("reload did not start as one pulse");
   chk_reload_cause: assert property (reload_start |->
      $past(write_strobe && addr == tx_regs_pkg::ADDR_MEMORY_RELOAD && write_data[4]))
      else $error("reload started without a trigger write");
   cover property (wr_ovr && write_data[15]);
   cover property ($fell(baseband_blank) && blank_len == 5'h15);
   cover property (reload_start);
endmodule : tx_regs_checker

// *** tx_regs_test.sv ***
// Self-checking bench for the transmit control register bank.
// Drives all inputs itself; reads are scored through a queue by a watcher process.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR at %0t: got %h expected %h", $time, g, e); end end
module tx_regs_test;
   logic        clock = 1'b0, rst = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0;
   logic        gain_change = 1'b0, reload_done = 1'b0, pend = 1'b0;
   logic        baseband_blank, common_mode_adjust, reload_start, reload_busy, tx_power_manual;
   logic [4:0]  addr = 5'h00, first_control_converter;
   logic [15:0] write_data = 16'h0000, read_data, tx_synth_word, v, w, p;
   logic [5:0]  converter_two_auto = 6'h00, second_control_converter, saturation_threshold;
   logic [3:0]  general_outputs_auto = 4'h0, gpo;
   logic [11:0] tx_power_code;
   logic [15:0] exp_q[$];
   int          n_fail = 0, total_checks = 0, cycles = 0, n;
   int          blank_ns[4] = '{0, 230, 540, 850};
   tx_regs dut (.clock, .rst, .addr, .write_data, .write_strobe, .read_strobe, .read_data,
      .gain_change, .converter_two_auto, .general_outputs_auto, .reload_done,
      .baseband_blank, .common_mode_adjust, .saturation_threshold, .first_control_converter,
      .second_control_converter, .general_output_one(gpo[0]), .general_output_two(gpo[1]),
      .general_output_three(gpo[2]), .general_output_four(gpo[3]), .tx_synth_word,
      .tx_power_code, .tx_power_manual, .reload_start, .reload_busy);
   always #20 clock = ~clock;
   // Read data stand only in the cycle after the strobe, so look mid-cycle
   always @(posedge clock) pend <= read_strobe;
   always @(negedge clock) if (pend) `CHK(read_data, exp_q.pop_front())
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         test_done();
      end
   end
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask : wr
   task rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(posedge clock);
      addr <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
   endtask : rd
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial begin
      void'($urandom(32'h8A1A899E));
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rd(5'h15, 16'h001F);
      rd(5'h00, 16'h0000);
      rd(5'h05, 16'h0000);
      `CHK(saturation_threshold, 6'h1F)
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         v = 16'($urandom);
         w = 16'($urandom);
         // Power codes stay at or below +10 dBm, i.e. 90 dB above the -80 dBm floor
         p = {12'($urandom_range(0, 2880)), 3'h0, 1'($urandom)};
         v[15] = i[0];
         converter_two_auto <= 6'($urandom);
         general_outputs_auto <= 4'($urandom);
         wr(5'h15, {w[15:7], 1'b0, 6'h1F});
         wr(5'h16, v);
         wr(5'h1A, w);
         wr(5'h1C, p);
         repeat (3) @(posedge clock);
         #1;
         `CHK(first_control_converter, v[4:0])
         `CHK(second_control_converter, v[15] ? v[10:5] : converter_two_auto)
         `CHK(gpo, v[15] ? v[14:11] : general_outputs_auto)
         `CHK(tx_synth_word, w)
         `CHK({tx_power_code, tx_power_manual}, {p[15:4], p[0]})
         `CHK(common_mode_adjust, 1'b0)
         `CHK(saturation_threshold, 6'h1F)
         rd(5'h15, {w[15:7], 1'b0, 6'h1F});
         rd(5'h16, v);
         rd(5'h1C, 16'h0000);
      end
      $display("field test done");
      for (int c = 0; c < 4; c++) begin
         wr(5'h15, 16'h001F | 16'(c << 7));
         gain_change <= 1'b1;
         @(posedge clock);
         gain_change <= 1'b0;
         n = 0;
         repeat (30) begin
            #1;
            if (baseband_blank === 1'b1) n++;
            @(posedge clock);
         end
         `CHK(n, blank_ns[c] / 40)
      end
      $display("blanking test done");
      wr(5'h1F, 16'h0010);
      #1;
      `CHK({reload_start, reload_busy}, 2'h3)
      wr(5'h1F, 16'h0010);
      #1;
      `CHK(reload_start, 1'b0)
      @(posedge clock);
      reload_done <= 1'b1;
      @(posedge clock);
      reload_done <= 1'b0;
      #1;
      `CHK(reload_busy, 1'b0)
      rd(5'h1F, 16'h0000);
      $display("reload test done");
      repeat (2) @(posedge clock);
      test_done();
   end
endmodule : tx_regs_test
bind tx_regs tx_regs_checker chk (.clock, .rst, .write_strobe, .gain_change, .addr,
   .write_data, .converter_two_auto, .baseband_blank, .reload_start, .reload_busy,
   .tx_power_manual, .general_output_one, .general_output_two, .general_output_three,
   .general_output_four, .first_control_converter, .second_control_converter,
   .tx_synth_word, .tx_power_code);
